// ==== sac_regs.svh ====
`ifndef SAC_REGS_SVH
`define SAC_REGS_SVH
`define SAC_NBITS 16
`define SAC_CODE_ZERO 16'h0000
`define SAC_CODE_FULL 16'hffff
`define SAC_LEAD_EDGES 5
`define SAC_SWITCH_CYCLES 2
`define SAC_SETTLE_CYCLES 2
`define SAC_FIFO_DEPTH 4
`endif

// ==== sac_pkg.sv ====
package sac_pkg;
    typedef struct packed {
        logic posGround;
        logic negGround;
        logic sampleConnect;
    } sac_switch_type;
    typedef struct packed {
        logic overRange;
        logic underRange;
    } sac_range_type;
    typedef enum logic [2:0] {
        SAC_POWERDOWN = 3'b000,
        SAC_OPEN_GND = 3'b001,
        SAC_HOLD = 3'b011,
        SAC_TRIAL = 3'b010,
        SAC_DECIDE = 3'b110,
        SAC_FINISH = 3'b111
    } sac_state_type;
endpackage

// ==== sac_fifo.sv ====
`timescale 1ns/100ps
`default_nettype none
module sac_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 4
) (
    input wire logic clk, // core clock
    input wire logic sys_rst, // async reset
    input wire logic inValid, // write request
    output logic inReady, // space available
    input wire logic [WIDTH-1:0] inData, // write word
    output logic outValid, // word available
    input wire logic outReady, // drain accepts
    output logic [WIDTH-1:0] outData // head word
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wrPtr_r;
    logic [AW-1:0] rdPtr_r;
    logic [AW:0] count_r;
    logic doWr;
    logic doRd;
    assign inReady = (count_r != (AW+1)'(DEPTH));
    assign outValid = (count_r != '0);
    assign outData = mem[rdPtr_r];
    assign doWr = inValid && inReady;
    assign doRd = outValid && outReady;
    always_ff @(posedge clk) begin
        if (doWr) begin
            mem[wrPtr_r] <= inData;
        end
    end
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            wrPtr_r <= '0;
            rdPtr_r <= '0;
            count_r <= '0;
        end else begin
            if (doWr) begin
                wrPtr_r <= (wrPtr_r == AW'(DEPTH-1)) ? '0 : wrPtr_r + 1'b1;
            end
            if (doRd) begin
                rdPtr_r <= (rdPtr_r == AW'(DEPTH-1)) ? '0 : rdPtr_r + 1'b1;
            end
            count_r <= count_r + (AW+1)'(doWr) - (AW+1)'(doRd);
        end
    end
endmodule
`default_nettype wire

// ==== sac_converter.sv ====
// Overview of operation
// - chip-select falling edge starts conversion
// - open ground switches, then disconnect arrays from inputs
// - test 16 bits MSB first by comparator
// - after last bit, reacquire and form code
// - code is straight unsigned binary
// - over-range saturates to all ones
// - under-range without over-range saturates to all zeros
// - result belongs to this conversion's sample if read after SAC_FINISH, else an older code
// - up to 100 kSPS, powered down between
// - each result is a 16-bit word
// - data output high impedance while select high
// - after fifth falling clock, drive leading zero
// - shift result MSB first on falling edges
`timescale 1ns/100ps
`default_nettype none
`include "sac_regs.svh"
module sac_converter
    import sac_pkg::*;
(
    input wire logic clk, // internal conversion clock
    input wire logic sys_rst, // async reset, active high
    input wire logic convStart_n, // chip-select pin, active low
    input wire logic host_shift_clock, // host serial clock pin
    input wire logic compHigh, // comparator: sample above trial level
    input wire logic overRange, // analog input above reference span
    input wire logic underRange, // analog input below ground
    output logic pos_array_ground_switch, // closed while acquiring
    output logic neg_array_ground_switch, // closed while acquiring
    output logic sampleConnect, // arrays tied to inputs
    output logic [`SAC_NBITS-1:0] trialBits, // array elements at reference
    output logic powerUp, // analog core powered
    output logic dataOut, // serial data output level
    output logic dataOutEn, // serial data output enable
    output logic [`SAC_NBITS-1:0] resultCode, // last completed code
    output logic resultValid // pulse when a code completes
);
    logic [1:0] csSync_r;
    logic [1:0] sckSync_r;
    logic csPrev_r;
    logic sckPrev_r;
    logic csLow;
    logic csFall;
    logic sckFall;
    sac_state_type state_r;
    sac_switch_type sw_r;
    sac_range_type range_r;
    logic [3:0] bitIdx_r;
    logic [1:0] waitCnt_r;
    logic [`SAC_NBITS-1:0] sar_r;
    logic [`SAC_NBITS-1:0] code_nxt;
    logic fifoInValid;
    logic fifoInReady;
    logic fifoOutValid;
    logic fifoOutReady;
    logic [`SAC_NBITS-1:0] fifoOutData;
    logic [`SAC_NBITS-1:0] shift_r;
    logic [4:0] edgeCnt_r;
    logic [4:0] bitsLeft_r;
    logic readLoad;

    // pins pass two flops before any logic reads them
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            csSync_r <= 2'h3;
            sckSync_r <= 2'h0;
            csPrev_r <= 1'b1;
            sckPrev_r <= 1'b0;
        end else begin
            csSync_r <= {csSync_r[0], convStart_n};
            sckSync_r <= {sckSync_r[0], host_shift_clock};
            csPrev_r <= csSync_r[1];
            sckPrev_r <= sckSync_r[1];
        end
    end
    assign csLow = !csSync_r[1];
    assign csFall = csPrev_r && !csSync_r[1];
    assign sckFall = sckPrev_r && !sckSync_r[1];

    // saturated codes replace the search result on range faults
    always_comb begin
        if (range_r.overRange) begin
            code_nxt = `SAC_CODE_FULL;
        end else if (range_r.underRange) begin
            code_nxt = `SAC_CODE_ZERO;
        end else begin
            code_nxt = sar_r;
        end
    end

    // sequencer runs on clk only, never on the host clock
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_r <= SAC_POWERDOWN;
            sw_r <= '{posGround: 1'b1, negGround: 1'b1, sampleConnect: 1'b1};
            range_r <= '0;
            bitIdx_r <= 4'hf;
            waitCnt_r <= 2'h0;
            sar_r <= '0;
        end else begin
            unique case (state_r)
                SAC_POWERDOWN: begin
                    if (csFall) begin
                        sw_r.posGround <= 1'b0;
                        sw_r.negGround <= 1'b0;
                        waitCnt_r <= 2'(`SAC_SWITCH_CYCLES - 1);
                        state_r <= SAC_OPEN_GND;
                    end
                end
                SAC_OPEN_GND: begin
                    if (waitCnt_r == 2'h0) begin
                        sw_r.sampleConnect <= 1'b0;
                        range_r <= '{overRange: overRange, underRange: underRange};
                        sar_r <= '0;
                        bitIdx_r <= 4'hf;
                        state_r <= SAC_HOLD;
                    end else begin
                        waitCnt_r <= waitCnt_r - 2'h1;
                    end
                end
                SAC_HOLD: begin
                    sar_r[bitIdx_r] <= 1'b1;
                    waitCnt_r <= 2'(`SAC_SETTLE_CYCLES - 1);
                    state_r <= SAC_TRIAL;
                end
                SAC_TRIAL: begin
                    if (waitCnt_r == 2'h0) begin
                        state_r <= SAC_DECIDE;
                    end else begin
                        waitCnt_r <= waitCnt_r - 2'h1;
                    end
                end
                SAC_DECIDE: begin
                    sar_r[bitIdx_r] <= compHigh;
                    if (bitIdx_r == 4'h0) begin
                        state_r <= SAC_FINISH;
                    end else begin
                        bitIdx_r <= bitIdx_r - 4'h1;
                        state_r <= SAC_HOLD;
                    end
                end
                SAC_FINISH: begin
                    sw_r <= '{posGround: 1'b1, negGround: 1'b1, sampleConnect: 1'b1};
                    state_r <= SAC_POWERDOWN;
                end
                default: state_r <= SAC_POWERDOWN;
            endcase
        end
    end

    assign fifoInValid = (state_r == SAC_FINISH);

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pos_array_ground_switch <= 1'b1;
            neg_array_ground_switch <= 1'b1;
            sampleConnect <= 1'b1;
            trialBits <= '0;
            powerUp <= 1'b0;
            resultCode <= '0;
            resultValid <= 1'b0;
        end else begin
            pos_array_ground_switch <= sw_r.posGround;
            neg_array_ground_switch <= sw_r.negGround;
            sampleConnect <= sw_r.sampleConnect;
            trialBits <= sar_r;
            powerUp <= (state_r != SAC_POWERDOWN);
            resultValid <= fifoInValid && fifoInReady;
            if (fifoInValid && fifoInReady) begin
                resultCode <= code_nxt;
            end
        end
    end

    // a full queue would drop the code; draining keeps it at one word at most
    sac_fifo #(
        .WIDTH(`SAC_NBITS),
        .DEPTH(`SAC_FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .sys_rst(sys_rst),
        .inValid(fifoInValid),
        .inReady(fifoInReady),
        .inData(code_nxt),
        .outValid(fifoOutValid),
        .outReady(fifoOutReady),
        .outData(fifoOutData)
    );

    // load the word at the leading zero; unread words drain while converting,
    // so the shifted code is this frame's if the fifth falling clock comes after SAC_FINISH, else an older one
    assign readLoad = csLow && sckFall && (edgeCnt_r == 5'(`SAC_LEAD_EDGES - 1));
    assign fifoOutReady = fifoOutValid && (readLoad
        || (state_r != SAC_POWERDOWN && state_r != SAC_FINISH));

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            edgeCnt_r <= '0;
            bitsLeft_r <= '0;
            shift_r <= '0;
            dataOut <= 1'b0;
            dataOutEn <= 1'b0;
        end else if (!csLow) begin
            edgeCnt_r <= '0;
            bitsLeft_r <= '0;
            dataOut <= 1'b0;
            dataOutEn <= 1'b0;
        end else if (sckFall) begin
            if (edgeCnt_r < 5'(`SAC_LEAD_EDGES)) begin
                edgeCnt_r <= edgeCnt_r + 5'h1;
            end
            if (edgeCnt_r == 5'(`SAC_LEAD_EDGES - 1)) begin
                dataOutEn <= 1'b1;
                dataOut <= 1'b0;
                shift_r <= fifoOutData;
                bitsLeft_r <= 5'(`SAC_NBITS);
            end else if (bitsLeft_r != 5'h0) begin
                dataOut <= shift_r[`SAC_NBITS-1];
                shift_r <= {shift_r[`SAC_NBITS-2:0], 1'b0};
                bitsLeft_r <= bitsLeft_r - 5'h1;
            end else begin
                dataOut <= 1'b0;
            end
        end
    end

    hiz_when_high_a: assert property (@(posedge clk) disable iff (sys_rst)
        !csSync_r[1] || !$past(csSync_r[1]) || !dataOutEn)
        else $error("data output enabled while select high");
    lead_zero_a: assert property (@(posedge clk) disable iff (sys_rst)
        $rose(dataOutEn) |-> !dataOut)
        else $error("leading bit not zero");
    start_opens_gnd_a: assert property (@(posedge clk) disable iff (sys_rst)
        csFall && state_r == SAC_POWERDOWN |=> !sw_r.posGround && !sw_r.negGround
        && sw_r.sampleConnect)
        else $error("ground switches not opened first");
    conv_length_a: assert property (@(posedge clk) disable iff (sys_rst)
        state_r == SAC_HOLD && bitIdx_r == 4'hf |-> ##64 state_r == SAC_FINISH)
        else $error("search did not take sixteen steps");
    finish_reacquire_a: assert property (@(posedge clk) disable iff (sys_rst)
        state_r == SAC_FINISH |=> state_r == SAC_POWERDOWN && sw_r.sampleConnect)
        else $error("no return to acquisition");
    over_sat_a: assert property (@(posedge clk) disable iff (sys_rst)
        fifoInValid && range_r.overRange |=> resultCode == `SAC_CODE_FULL)
        else $error("over-range not saturated");
    under_sat_a: assert property (@(posedge clk) disable iff (sys_rst)
        fifoInValid && !range_r.overRange && range_r.underRange
        |=> resultCode == `SAC_CODE_ZERO)
        else $error("under-range not saturated");
    result_same_a: assert property (@(posedge clk) disable iff (sys_rst)
        readLoad && state_r == SAC_POWERDOWN
        |-> fifoOutValid && fifoOutData == resultCode)
        else $error("result is not this sample");
    power_down_a: assert property (@(posedge clk) disable iff (sys_rst)
        state_r == SAC_POWERDOWN ##1 state_r == SAC_POWERDOWN |-> !powerUp)
        else $error("powered while idle");
    conv_c: cover property (@(posedge clk) disable iff (sys_rst) resultValid);
    over_c: cover property (@(posedge clk) disable iff (sys_rst) fifoInValid && range_r.overRange);
    shift_c: cover property (@(posedge clk) disable iff (sys_rst)
        dataOutEn && bitsLeft_r == 5'h1 && sckFall);
endmodule
`default_nettype wire

// ==== sac_host_model.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "sac_regs.svh"
module sac_host_model (
    input wire logic clk, // core clock
    input wire logic [`SAC_NBITS-1:0] trialBits, // array trial word
    input wire logic dataOut, // serial data level
    input wire logic dataOutEn, // serial data enable
    output logic compHigh, // comparator decision
    output logic overRange, // input above span
    output logic underRange, // input below ground
    output logic convStart_n, // select, active low
    output logic host_shift_clock // serial clock
);
    logic [`SAC_NBITS-1:0] sample;
    logic sdo;
    // the held sample against the trial level; high keeps the bit
    assign compHigh = sample >= trialBits;
    // nothing pulls the line; a released output shows the inverse so a stray sample shows up
    assign sdo = dataOutEn ? dataOut : !dataOut;
    initial begin
        sample = 16'h0000;
        overRange = 1'b0;
        underRange = 1'b0;
        convStart_n = 1'b1;
        host_shift_clock = 1'b1;
    end
    task automatic start(input logic [15:0] s, input logic ov, input logic un);
        @(negedge clk);
        sample = s;
        overRange = ov;
        underRange = un;
        convStart_n = 1'b0;
    endtask
    // clock idles high and toggles only here; bits are taken just before the next fall
    task automatic read(output logic [15:0] w, output logic lead, output logic bad);
        bad = 1'b0;
        lead = 1'b1;
        w = 16'h0000;
        for (int i = 1; i <= 22; i++) begin
            if (i >= 6) begin
                if (dataOutEn !== 1'b1) bad = 1'b1;
                if (i == 6) lead = sdo;
                else w[22 - i] = sdo;
            end else if (dataOutEn !== 1'b0) begin
                bad = 1'b1;
            end
            host_shift_clock = 1'b0;
            #160;
            host_shift_clock = 1'b1;
            #160;
        end
    endtask
    task automatic stop();
        @(negedge clk);
        convStart_n = 1'b1;
    endtask
endmodule
`default_nettype wire

// ==== testbench.sv ====
`timescale 1ns/100ps
`default_nettype none
module testbench;
    logic clk, sys_rst, compHigh, overRange, underRange, convStart_n, host_shift_clock;
    logic posSw, negSw, sampleConnect, powerUp, dataOut, dataOutEn, resultValid;
    logic [15:0] trialBits, resultCode;
    int errors, checks_done, pulses;
    logic [15:0] codes [6] = '{16'h0000, 16'h0001, 16'h7fff, 16'h8000, 16'h8001, 16'hffff};

    sac_converter dut (.clk(clk), .sys_rst(sys_rst), .convStart_n(convStart_n),
        .host_shift_clock(host_shift_clock), .compHigh(compHigh), .overRange(overRange),
        .underRange(underRange), .pos_array_ground_switch(posSw),
        .neg_array_ground_switch(negSw), .sampleConnect(sampleConnect),
        .trialBits(trialBits), .powerUp(powerUp), .dataOut(dataOut),
        .dataOutEn(dataOutEn), .resultCode(resultCode), .resultValid(resultValid));
    sac_host_model host (.clk(clk), .trialBits(trialBits), .dataOut(dataOut),
        .dataOutEn(dataOutEn), .compHigh(compHigh), .overRange(overRange),
        .underRange(underRange), .convStart_n(convStart_n),
        .host_shift_clock(host_shift_clock));

    always #20 clk = ~clk;
    always @(posedge clk) if (resultValid === 1'b1) pulses++;

    task automatic check(input logic ok, input string msg);
        checks_done++;
        if (ok !== 1'b1) begin
            errors++;
            $display("BAD %0t %s", $time, msg);
        end
    endtask
    task automatic complete_run();
        if (errors == 0 && checks_done > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic reset_values();
        check({posSw, negSw, sampleConnect, powerUp, dataOutEn, resultValid} === 6'b111000
            && resultCode === 16'h0000 && trialBits === 16'h0000, "reset values");
    endtask
    task automatic convert(input logic [15:0] s, input logic ov, input logic un,
        input logic [15:0] exp);
        logic [15:0] w;
        logic lead, bad;
        int p;
        p = pulses;
        host.start(s, ov, un);
        repeat (40) @(negedge clk);
        check({powerUp, sampleConnect, posSw, negSw} === 4'b1000, "mid conversion");
        repeat (70) @(negedge clk);
        check(resultCode === exp && pulses == p + 1, "result word");
        check({powerUp, sampleConnect, posSw, negSw} === 4'b0111, "not reacquiring");
        host.read(w, lead, bad);
        check(w === exp && lead === 1'b0 && !bad, "serial word");
        host.stop();
        repeat (4) @(negedge clk);
        check(dataOutEn === 1'b0, "output not released");
        repeat (4) @(negedge clk);
    endtask
    task automatic test_codes();
        foreach (codes[i]) convert(codes[i], 1'b0, 1'b0, codes[i]);
    endtask
    task automatic test_range();
        convert(16'h1234, 1'b1, 1'b0, 16'hffff);
        convert(16'h5678, 1'b0, 1'b1, 16'h0000);
        convert(16'h4321, 1'b1, 1'b1, 16'hffff);
    endtask
    // unread codes must not reach a later frame: each read returns its own sample
    task automatic test_fill();
        logic [15:0] w;
        logic lead, bad;
        logic [15:0] expv [5] = '{16'h6666, 16'h7777, 16'h8888, 16'h9999, 16'haaaa};
        for (int i = 0; i < 5; i++) begin
            host.start(16'h1111 * (i + 1), 1'b0, 1'b0);
            repeat (110) @(negedge clk);
            host.stop();
            repeat (8) @(negedge clk);
        end
        for (int i = 0; i < 5; i++) begin
            host.start(16'h1111 * (i + 6), 1'b0, 1'b0);
            repeat (110) @(negedge clk);
            host.read(w, lead, bad);
            host.stop();
            repeat (8) @(negedge clk);
            check(w === expv[i] && lead === 1'b0 && !bad, "stale word");
        end
    endtask
    task automatic test_reset();
        @(negedge clk);
        sys_rst = 1'b1;
        repeat (2) @(negedge clk);
        reset_values();
        sys_rst = 1'b0;
        repeat (2) @(negedge clk);
        convert(16'hbeef, 1'b0, 1'b0, 16'hbeef);
    endtask

    initial begin
        #1000000;
        errors++;
        complete_run();
    end
    initial begin
        clk = 1'b0;
        sys_rst = 1'b1;
        errors = 0;
        checks_done = 0;
        pulses = 0;
        repeat (5) @(negedge clk);
        reset_values();
        sys_rst = 1'b0;
        test_codes();
        test_range();
        test_fill();
        test_reset();
        complete_run();
    end
endmodule
`default_nettype wire
